// file: rtl/cpb_top.v
// programmable buffers and acceptance filters behind a wishbone slave
// Overview of operation
// - a set direction bit makes its buffer transmit, a clear bit receive
// - direction bits reset to zero; two low select bits read zero
// - receive-role data bytes hold received payload and are read-only
// - transmit-role data bytes are read-write and feed the sent payload
// - receive role loads received length code; 1001 to 1111 reserved
// - software writes transmit length code 0 to 8; avoid reserved codes
// - receive role bit 6 flags a remote request frame
// - receive role bits 7, 5, 4 read zero
// - transmit role bit 6 sets the sent frame's remote request bit
// - transmit role bits 7, 5, 4 read zero whatever is written
// - transmit extended id low byte is writable, reset value undefined
// - buffer registers exist only in modes 1 and 2; this block also maps them in mode 3
// - sixteen filters; filters 6 to 15 only in modes 1 and 2; this block also enables them in mode 3
// - filter upper eleven bits compare standard id or extended bits 28-18
// - filter format bit: one accepts extended frames, zero standard
// - extended frames also compare bits 17-0 from low and extended bytes
// - a pending or active send keeps its buffer read-only
`default_nettype none
`include "cpb_map.vh"
module cpb_top (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // receive engine frame delivery
    input wire rx_valid_i,
    input wire [2:0] rx_buf_i,
    input wire rx_ext_i,
    input wire [28:0] rx_id_i,
    input wire [28:0] rx_id_en_i,
    input wire rx_rtr_i,
    input wire [3:0] rx_dlc_i,
    input wire [63:0] rx_data_i,
    // transmit engine status and view
    input wire [5:0] tx_busy_i,
    input wire [2:0] tx_sel_i,
    output reg [5:0] buffer_tx_role_o,
    output reg tx_rtr_o,
    output reg [3:0] tx_dlc_o,
    output reg [7:0] tx_eidl_o,
    output reg [63:0] tx_data_o,
    // filter result
    output reg [15:0] flt_hit_o,
    output reg [1:0] mode_o
);
    reg [7:0] bsel_ff;
    reg [1:0] mode_ff;
    reg [7:0] rxstat_ff;
    reg [7:0] flt_ff [0:63];
    wire [9:0] adr;
    wire req;
    wire wr;
    wire in_buf;
    wire in_flt;
    wire [2:0] buf_n;
    wire [3:0] buf_idx;
    wire [3:0] flt_n;
    wire [1:0] flt_idx;
    wire buf_live;
    wire flt_live;
    wire [7:0] bank_rd [0:5];
    wire [7:0] bk_eidl [0:5];
    wire bk_rtr [0:5];
    wire [3:0] bk_dlc [0:5];
    wire [63:0] bk_data [0:5];
    wire [15:0] hit;
    reg [7:0] rd_byte;
    reg hit_map;

    assign adr = wb_adr_i[11:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign in_buf = (adr[9:8] == 2'h1);
    assign in_flt = (adr[9:8] == 2'h2);
    assign buf_n = adr[6:4];
    assign buf_idx = adr[3:0];
    assign flt_n = adr[5:2];
    assign flt_idx = adr[1:0];
    // buffers and upper filters vanish in mode 0
    assign buf_live = in_buf && (adr[7] == 1'b0) && (buf_n < 3'd6) &&
                      (mode_ff != 2'h0);
    assign flt_live = in_flt && (adr[7:6] == 2'h0) &&
                      ((mode_ff != 2'h0) || (flt_n < 4'd6));

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_buf
            cpb_buf_bank u_bank (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .sw_we_i(wr && buf_live && (buf_n == g)),
                .sw_idx_i(buf_idx),
                .sw_wdat_i(wb_dat_i[7:0]),
                .sw_rdat_o(bank_rd[g]),
                .tx_role_i(bsel_ff[g+2]),
                .tx_busy_i(tx_busy_i[g]),
                .rx_load_i(rx_valid_i && (rx_buf_i == g) && (mode_ff != 2'h0)),
                .rx_eidl_i(rx_id_i[7:0]),
                .rx_rtr_i(rx_rtr_i),
                .rx_dlc_i(rx_dlc_i),
                .rx_data_i(rx_data_i),
                .tx_eidl_o(bk_eidl[g]),
                .tx_rtr_o(bk_rtr[g]),
                .tx_dlc_o(bk_dlc[g]),
                .tx_data_o(bk_data[g])
            );
        end
        for (g = 0; g < 16; g = g + 1) begin : g_flt
            cpb_flt_match u_match (
                .sidh_i(flt_ff[4*g]),
                .sidl_i(flt_ff[4*g+1]),
                .eidh_i(flt_ff[4*g+2]),
                .eidl_i(flt_ff[4*g+3]),
                .id_i(rx_id_i),
                .id_en_i(rx_id_en_i),
                .ext_i(rx_ext_i),
                .hit_o(hit[g])
            );
        end
    endgenerate

    // register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            bsel_ff <= `CPB_BSEL_RESET;
            mode_ff <= `CPB_MODE_RESET;
        end else if (wr) begin
            if (adr == `CPB_BSEL_ADDR) begin
                bsel_ff <= wb_dat_i[7:0] & `CPB_BSEL_MASK;
            end else if (adr == `CPB_MODE_ADDR) begin
                mode_ff <= wb_dat_i[1:0];
            end
        end
    end

    // filter contents are undefined after reset, so no reset term
    always @(posedge clk_i) begin
        if (wr && flt_live) begin
            if (flt_idx == `CPB_FLT_SIDL_IDX) begin
                flt_ff[{flt_n, flt_idx}] <= wb_dat_i[7:0] & `CPB_SIDL_MASK;
            end else begin
                flt_ff[{flt_n, flt_idx}] <= wb_dat_i[7:0];
            end
        end
    end

    // last delivery buffer and format, visible to software
    always @(posedge clk_i) begin
        if (rst_i) begin
            rxstat_ff <= 8'h00;
        end else if (rx_valid_i) begin
            rxstat_ff <= {4'h0, rx_ext_i, rx_buf_i};
        end
    end

    // read mux
    always @* begin
        rd_byte = 8'h00;
        hit_map = 1'b1;
        if (adr == `CPB_BSEL_ADDR) begin
            rd_byte = bsel_ff;
        end else if (adr == `CPB_MODE_ADDR) begin
            rd_byte = {6'h00, mode_ff};
        end else if (adr == `CPB_RXSTAT_ADDR) begin
            rd_byte = rxstat_ff;
        end else if (buf_live) begin
            rd_byte = bank_rd[buf_n];
        end else if (flt_live) begin
            rd_byte = flt_ff[{flt_n, flt_idx}];
        end else begin
            hit_map = 1'b0;
        end
    end

    // one-cycle answer; unmapped addresses get err
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && hit_map;
            wb_err_o <= req && !hit_map;
            wb_dat_o <= (req && hit_map && !wb_we_i) ? {24'h00_0000, rd_byte} :
                        32'h0000_0000;
        end
    end

    // engine-facing outputs registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            buffer_tx_role_o <= 6'h00;
            tx_rtr_o <= 1'b0;
            tx_dlc_o <= 4'h0;
            tx_eidl_o <= 8'h00;
            tx_data_o <= 64'h0;
            flt_hit_o <= 16'h0000;
            mode_o <= 2'h0;
        end else begin
            buffer_tx_role_o <= bsel_ff[7:2];
            mode_o <= mode_ff;
            if (tx_sel_i < 3'd6) begin
                tx_rtr_o <= bk_rtr[tx_sel_i];
                tx_dlc_o <= bk_dlc[tx_sel_i];
                tx_eidl_o <= bk_eidl[tx_sel_i];
                tx_data_o <= bk_data[tx_sel_i];
            end
            // upper filters disabled in mode 0
            flt_hit_o <= (mode_ff == 2'h0) ? (hit & 16'h003F) : hit;
        end
    end
endmodule // cpb_top
`default_nettype wire

// file: rtl/cpb_map.vh
// register map and field constants for the programmable buffer and filter block
`ifndef CPB_MAP_VH
`define CPB_MAP_VH
`define CPB_NUM_BUF 6
`define CPB_NUM_FLT 16
`define CPB_NUM_FLT_M0 6
`define CPB_BSEL_ADDR 10'h000
`define CPB_MODE_ADDR 10'h004
`define CPB_RXSTAT_ADDR 10'h008
`define CPB_BUF_BASE 10'h100
`define CPB_BUF_STRIDE_SH 6
`define CPB_BUF_EIDL_IDX 4'h0
`define CPB_BUF_DLC_IDX 4'h1
`define CPB_BUF_DATA_IDX 4'h8
`define CPB_FLT_BASE 10'h200
`define CPB_FLT_STRIDE_SH 4
`define CPB_FLT_SIDH_IDX 2'h0
`define CPB_FLT_SIDL_IDX 2'h1
`define CPB_FLT_EIDH_IDX 2'h2
`define CPB_FLT_EIDL_IDX 2'h3
`define CPB_BSEL_MASK 8'hFC
`define CPB_BSEL_RESET 8'h00
`define CPB_DLC_RTR_BIT 6
`define CPB_DLC_TX_MASK 8'h4F
`define CPB_DLC_MAX 4'h8
`define CPB_SIDL_MASK 8'hEB
`define CPB_SIDL_EXT_BIT 3
`define CPB_MODE_RESET 2'h0
`endif

// file: rtl/cpb_flt_match.v
// one acceptance filter compare against an incoming identifier
`default_nettype none
`include "cpb_map.vh"
module cpb_flt_match (
    // filter contents
    input wire [7:0] sidh_i,
    input wire [7:0] sidl_i,
    input wire [7:0] eidh_i,
    input wire [7:0] eidl_i,
    // frame identifier and per-bit compare enables
    input wire [28:0] id_i,
    input wire [28:0] id_en_i,
    input wire ext_i,
    output wire hit_o
);
    wire [28:0] flt_id;
    wire fmt_sel;
    // upper 11 bits sit at 28:18 for both formats; std ids are presented there too
    assign flt_id = {sidh_i, sidl_i[7:5], sidl_i[1:0], eidh_i, eidl_i};
    assign fmt_sel = sidl_i[`CPB_SIDL_EXT_BIT];
    assign hit_o = (fmt_sel == ext_i) &&
                   (((flt_id ^ id_i) & id_en_i) == 29'h0000_0000);
endmodule // cpb_flt_match
`default_nettype wire

// file: rtl/cpb_buf_bank.v
// one programmable buffer: id low byte, length code and eight data bytes
`default_nettype none
`include "cpb_map.vh"
module cpb_buf_bank (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // software access
    input wire sw_we_i,
    input wire [3:0] sw_idx_i,
    input wire [7:0] sw_wdat_i,
    output reg [7:0] sw_rdat_o,
    // role and locks
    input wire tx_role_i,
    input wire tx_busy_i,
    // receive load
    input wire rx_load_i,
    input wire [7:0] rx_eidl_i,
    input wire rx_rtr_i,
    input wire [3:0] rx_dlc_i,
    input wire [63:0] rx_data_i,
    // transmit side view
    output wire [7:0] tx_eidl_o,
    output wire tx_rtr_o,
    output wire [3:0] tx_dlc_o,
    output wire [63:0] tx_data_o
);
    reg [7:0] eidl_ff;
    reg [7:0] dlc_ff;
    reg [7:0] data_ff [0:7];
    wire sw_ok;
    integer k;
    // rx role read-only, tx role locked while a send is pending
    assign sw_ok = sw_we_i && tx_role_i && !tx_busy_i;
    always @(posedge clk_i) begin
        if (rx_load_i && !tx_role_i) begin
            eidl_ff <= rx_eidl_i;
            // reserved protocol bits and bit 7 stored as zero
            dlc_ff <= {1'b0, rx_rtr_i, 2'b00, rx_dlc_i};
            for (k = 0; k < 8; k = k + 1) begin
                data_ff[k] <= rx_data_i[8*k +: 8];
            end
        end else if (sw_ok) begin
            if (sw_idx_i == `CPB_BUF_EIDL_IDX) begin
                eidl_ff <= sw_wdat_i;
            end else if (sw_idx_i == `CPB_BUF_DLC_IDX) begin
                dlc_ff <= sw_wdat_i & `CPB_DLC_TX_MASK;
            end else if (sw_idx_i[3]) begin
                data_ff[sw_idx_i[2:0]] <= sw_wdat_i;
            end
        end
    end
    always @* begin
        sw_rdat_o = 8'h00;
        if (sw_idx_i == `CPB_BUF_EIDL_IDX) begin
            sw_rdat_o = eidl_ff;
        end else if (sw_idx_i == `CPB_BUF_DLC_IDX) begin
            sw_rdat_o = dlc_ff & `CPB_DLC_TX_MASK;
        end else if (sw_idx_i[3]) begin
            sw_rdat_o = data_ff[sw_idx_i[2:0]];
        end
    end
    assign tx_eidl_o = eidl_ff;
    assign tx_rtr_o = dlc_ff[`CPB_DLC_RTR_BIT];
    assign tx_dlc_o = dlc_ff[3:0];
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_dat
            assign tx_data_o[8*g +: 8] = data_ff[g];
        end
    endgenerate
endmodule // cpb_buf_bank
`default_nettype wire

// file: tb/cpb_top_assertions.sv
// concurrent checks on the wishbone side of the buffer and filter block
`default_nettype none
module cpb_top_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // roles, filters and mode
    input wire logic [5:0] buffer_tx_role_o,
    input wire logic [15:0] flt_hit_o,
    input wire logic [1:0] mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request counts only while no answer is outstanding
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    sequence s_bsel_wr;
        req && wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h000;
    endsequence
    sequence s_answer;
        wb_ack_o;
    endsequence
    a_answer_time: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered in one cycle");
    a_no_spurious: assert property (!req |=> !wb_ack_o && !wb_err_o)
        else $error("answer without a request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside an ack");
    a_dat_byte: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_role_update: assert property (s_bsel_wr ##1 s_answer |=>
        buffer_tx_role_o == $past(wb_dat_i[7:2], 2)) else $error("roles not updated");
    a_sel_low: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h000)
        |-> wb_dat_o[1:0] == 2'b00) else $error("low select bits not zero");
    a_role_reset: assert property ($past(rst_i) |-> buffer_tx_role_o == 6'h00)
        else $error("roles not cleared by reset");
    a_buf_absent: assert property (req && mode_o == 2'h0 && wb_adr_i[11:10] == 2'h1
        |=> wb_err_o) else $error("buffer reachable in mode 0");
    a_flt_absent: assert property (req && mode_o == 2'h0 && wb_adr_i[11:10] == 2'h2
        && wb_adr_i[7:4] >= 4'h6 |=> wb_err_o) else $error("filter reachable in mode 0");
    a_hit_mode0: assert property (mode_o == 2'h0 && $past(mode_o) == 2'h0
        |-> flt_hit_o[15:6] == 10'h0) else $error("upper filter hit in mode 0");
endmodule // cpb_top_assertions
`default_nettype wire

// file: tb/cpb_can_node.sv
// behavioural receive engine standing in for the bus and the other nodes
`default_nettype none
module cpb_can_node (
    // clock
    input wire logic clk_i,
    // frame delivery
    output logic rx_valid_o = 1'b0,
    output logic [2:0] rx_buf_o = 3'h0,
    output logic rx_ext_o = 1'b0,
    output logic [28:0] rx_id_o = 29'h0,
    output logic [28:0] rx_id_en_o = 29'h0,
    output logic rx_rtr_o = 1'b0,
    output logic [3:0] rx_dlc_o = 4'h0,
    output logic [63:0] rx_data_o = 64'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic show(input logic e, input logic [28:0] id, input logic [28:0] en);
        @(posedge clk_i);
        rx_ext_o <= e;
        rx_id_o <= id;
        rx_id_en_o <= en;
    endtask
    // only legal length codes are ever sent
    task automatic deliver(input logic [2:0] b, input logic r, input logic [3:0] d,
        input logic [63:0] p);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_buf_o <= b;
        rx_rtr_o <= r;
        rx_dlc_o <= d;
        rx_data_o <= p;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        // payload lines must not keep showing the frame
        rx_data_o <= ~p;
    endtask
endmodule // cpb_can_node
`default_nettype wire

// file: tb/cpb_top_tb.sv
// self-checking bench for the buffer and filter register block
`default_nettype none
module cpb_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, e;
    logic [11:0] wb_adr = 12'h0;
    logic [3:0] wb_sel = 4'h0, tx_dlc;
    logic [31:0] wb_dat = 32'h0, wb_dat_o, q;
    logic [5:0] tx_busy = 6'h0, role;
    logic [2:0] tx_sel = 3'h0, rx_buf;
    logic wb_ack_o, wb_err_o, tx_rtr, rx_valid, rx_ext, rx_rtr;
    logic [7:0] tx_eidl;
    logic [63:0] tx_data, rx_data;
    logic [15:0] flt_hit;
    logic [1:0] mode;
    logic [28:0] rx_id, rx_id_en;
    logic [3:0] rx_dlc;
    int num_errors = 0, total_checks = 0;
    cpb_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .rx_valid_i(rx_valid), .rx_buf_i(rx_buf), .rx_ext_i(rx_ext), .rx_id_i(rx_id),
        .rx_id_en_i(rx_id_en), .rx_rtr_i(rx_rtr), .rx_dlc_i(rx_dlc), .rx_data_i(rx_data),
        .tx_busy_i(tx_busy), .tx_sel_i(tx_sel), .buffer_tx_role_o(role), .tx_rtr_o(tx_rtr),
        .tx_dlc_o(tx_dlc), .tx_eidl_o(tx_eidl), .tx_data_o(tx_data), .flt_hit_o(flt_hit),
        .mode_o(mode));
    cpb_can_node u_node (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_buf_o(rx_buf),
        .rx_ext_o(rx_ext), .rx_id_o(rx_id), .rx_id_en_o(rx_id_en), .rx_rtr_o(rx_rtr),
        .rx_dlc_o(rx_dlc), .rx_data_o(rx_data));
    initial forever #2.5 clk_i = ~clk_i;
    function automatic logic [11:0] ba(int n, int i);
        return 12'(32'h400 + n * 64 + i * 4);
    endfunction
    function automatic logic [11:0] fa(int n, int k);
        return 12'(32'h800 + n * 16 + k * 4);
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    // the request stands until the edge that samples the answer
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'h1;
        wb_dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            $display("Error at %0t: no answer got %h expected %h", $time, 1'b0, 1'b1);
            num_errors++;
        end
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_sel <= 4'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] x, input logic xe);
        wb(1'b0, a, 8'h00);
        chk({31'h0, e, q}, {31'h0, xe, 24'h0, x});
    endtask
    task t_reset;
        rdchk(12'h000, 8'h00, 1'b0);
        chk(role, 6'h00);
    endtask
    task t_mode0;
        rdchk(ba(0, 0), 8'h00, 1'b1);
        rdchk(fa(6, 0), 8'h00, 1'b1);
        wb(1'b1, fa(0, 1), 8'h08);
        rdchk(fa(0, 1), 8'h08, 1'b0);
    endtask
    task t_roles;
        wb(1'b1, 12'h010, 8'h01);
        wb(1'b1, 12'h000, 8'hFF);
        rdchk(12'h000, 8'hFC, 1'b0);
        chk(role, 6'h3F);
    endtask
    task t_tx;
        wb(1'b1, ba(2, 0), 8'h5A);
        // high bits set on purpose, length code kept legal
        wb(1'b1, ba(2, 1), 8'hF8);
        wb(1'b1, ba(2, 15), 8'hC3);
        rdchk(ba(2, 1), 8'h48, 1'b0);
        rdchk(ba(2, 0), 8'h5A, 1'b0);
        tx_sel <= 3'd2;
        repeat (2) @(posedge clk_i);
        chk({tx_rtr, tx_dlc, tx_eidl, tx_data[63:56]}, {1'b1, 4'h8, 16'h5AC3});
        wb(1'b1, ba(2, 1), 8'h08);
        repeat (2) @(posedge clk_i);
        chk({tx_rtr, tx_dlc}, 5'h08);
    endtask
    task t_busy;
        @(posedge clk_i);
        tx_busy <= 6'h04;
        wb(1'b1, ba(2, 15), 8'h11);
        rdchk(ba(2, 15), 8'hC3, 1'b0);
        tx_busy <= 6'h00;
    endtask
    task t_rx;
        wb(1'b1, 12'h000, 8'hF8);
        u_node.deliver(3'd0, 1'b1, 4'h8, 64'h0123456789ABCDEF);
        rdchk(ba(0, 1), 8'h48, 1'b0);
        rdchk(ba(0, 8), 8'hEF, 1'b0);
        wb(1'b1, ba(0, 8), 8'h00);
        rdchk(ba(0, 8), 8'hEF, 1'b0);
        u_node.deliver(3'd0, 1'b0, 4'h0, 64'h0);
        rdchk(ba(0, 1), 8'h00, 1'b0);
        // a frame aimed at a transmit buffer must not overwrite it
        wb(1'b1, ba(5, 8), 8'h77);
        u_node.deliver(3'd5, 1'b0, 4'h1, 64'h0);
        rdchk(ba(5, 8), 8'h77, 1'b0);
        rdchk(12'h020, 8'h05, 1'b0);
    endtask
    task t_rerun;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({role, mode, tx_rtr, tx_dlc, tx_eidl, flt_hit}, 37'h0);
        t_reset;
        rdchk(12'h010, 8'h00, 1'b0);
        rdchk(ba(1, 0), 8'h00, 1'b1);
    endtask
    task t_filter;
        wb(1'b1, fa(0, 0), 8'hA5);
        wb(1'b1, fa(0, 1), 8'h60);
        u_node.show(1'b0, {11'h52B, 18'h0}, 29'h1FFC0000);
        repeat (2) @(posedge clk_i);
        chk(flt_hit[0], 1'b1);
        u_node.show(1'b1, {11'h52B, 18'h0}, 29'h1FFC0000);
        repeat (2) @(posedge clk_i);
        chk(flt_hit[0], 1'b0);
        wb(1'b1, fa(0, 1), 8'h6B);
        wb(1'b1, fa(0, 2), 8'h12);
        wb(1'b1, fa(0, 3), 8'h34);
        u_node.show(1'b1, {11'h52B, 18'h31234}, 29'h1FFFFFFF);
        repeat (2) @(posedge clk_i);
        chk(flt_hit[0], 1'b1);
        u_node.show(1'b1, {11'h52B, 18'h31235}, 29'h1FFFFFFF);
        repeat (2) @(posedge clk_i);
        chk(flt_hit[0], 1'b0);
    endtask
    task end_of_test;
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_mode0;
        t_roles;
        t_tx;
        t_busy;
        t_rx;
        t_filter;
        t_rerun;
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        end_of_test;
    end
endmodule // cpb_top_tb
bind cpb_top cpb_top_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .buffer_tx_role_o(buffer_tx_role_o), .flt_hit_o(flt_hit_o), .mode_o(mode_o));
`default_nettype wire
